// File: rtl/rdc_map.svh
// offsets, field positions and fixed-point constants of the division block
// assumes an APB slave with 32-bit data, one aligned word per register
`ifndef RDC_MAP_SVH
`define RDC_MAP_SVH
`define RDC_NCFG        16
`define RDC_CTRL        4'h0
`define RDC_S1P_MIN     4'h1
`define RDC_S1P_MAX     4'h2
`define RDC_S1R_MIN     4'h3
`define RDC_S1R_MAX     4'h4
`define RDC_S2P_MIN     4'h5
`define RDC_S2P_MAX     4'h6
`define RDC_S2R_MIN     4'h7
`define RDC_S2R_MAX     4'h8
`define RDC_WIN_HI      4'h9
`define RDC_WIN_LO      4'ha
`define RDC_WIN_HYST    4'hb
`define RDC_THR         4'hc
`define RDC_THR_HYST    4'hd
`define RDC_WARN_THR    4'he
`define RDC_WARN_HYST   4'hf
`define RDC_A_STATUS    8'h40
`define RDC_A_RESULT    8'h44
`define RDC_A_CONS1     8'h48
`define RDC_A_CONS2     8'h4c
`define RDC_A_DIFF1     8'h50
`define RDC_A_DIFF2     8'h54
`define RDC_A_END       8'h58
`define RDC_B_RED1      0
`define RDC_B_RED2      1
`define RDC_B_RNG       2
`define RDC_B_DIFF1     4
`define RDC_B_DIFF2     5
`define RDC_B_CONS1     6
`define RDC_B_CONS2     9
`define RDC_B_WIN_EN    12
`define RDC_B_THR_EN    13
`define RDC_B_WARN_EN   14
`define RDC_B_WARN_LOW  15
`define RDC_B_SAT_HI    16
`define RDC_RNG_LIVE    2'h0
`define RDC_RNG_FULL    2'h1
`define RDC_RNG_VOLT    2'h2
`define RDC_CS_PRIM     3'h0
`define RDC_CS_RED      3'h1
`define RDC_CS_MAX      3'h2
`define RDC_CS_MIN      3'h3
`define RDC_CS_AVG      3'h4
`define RDC_RAW_LIVE_LO 18'h0_0fa0
`define RDC_RECIP_LIVE  12'h418
`define RDC_RECIP_FULL  12'h347
`define RDC_RECIP_VOLT  12'h68e
`define RDC_RECIP_SH    24
`define RDC_SAT_HI      32'h0003_0d40
`define RDC_DIV_STEPS   6'h1f
`endif

// File: rtl/rdc_pkg.sv
// types of the redundant analog division block
// assumes rdc_map.svh for all numeric constants
`default_nettype none
package rdc_pkg;
  typedef enum logic [2:0] {RDC_IDLE, RDC_SCALE, RDC_CONSOL, RDC_DIV, RDC_FINISH} rdc_state_e;
  typedef struct packed {
    logic [15:0] prim1;
    logic [15:0] red1;
    logic [15:0] prim2;
    logic [15:0] red2;
  } rdc_sample_s;
  typedef struct packed {
    logic cable_open;
    logic out_ovl;
    logic in_ovl;
    logic mismatch;
  } rdc_anom_s;
  typedef struct packed {
    logic signed [31:0] cons1;
    logic signed [31:0] cons2;
    logic signed [31:0] diff1;
    logic signed [31:0] diff2;
  } rdc_cons_s;
endpackage : rdc_pkg
`default_nettype wire

// File: rtl/rdc_top.sv
// scaling, consolidation, division and comparators of the redundant division block
// assumes raw samples in uA (current) or mV (voltage), a one-cycle sample strobe,
// and an APB master on the same clock
`include "rdc_map.svh"
`default_nettype none
module rdc_top (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                sample_valid,
  input  wire rdc_pkg::rdc_sample_s samples,
  input  wire rdc_pkg::rdc_anom_s  anomalies,
  output logic                     busy,
  output logic                     result_valid,
  output logic signed [31:0]       division_value,
  output rdc_pkg::rdc_cons_s       analog_data,
  output logic                     math_err,
  output logic                     window_compare_output,
  output logic                     threshold_output,
  output logic                     warning_output
);

  typedef struct packed {
    rdc_pkg::rdc_state_e         st;
    logic [`RDC_NCFG-1:0][31:0]  cfg;
    rdc_pkg::rdc_sample_s        smp;
    rdc_pkg::rdc_anom_s          anom;
    logic signed [31:0]          u1p;
    logic signed [31:0]          u1r;
    logic signed [31:0]          u2p;
    logic signed [31:0]          u2r;
    rdc_pkg::rdc_cons_s          cons;
    logic [31:0]                 quo;
    logic [32:0]                 rem;
    logic [31:0]                 dvs;
    logic                        neg;
    logic [5:0]                  cnt;
    logic signed [31:0]          result;
    logic                        err;
    logic                        valid;
    logic                        win_in;
    logic                        thr_over;
    logic                        warn_act;
    logic [31:0]                 rdata;
  } rdc_regs_s;

  rdc_regs_s state_ff;
  rdc_regs_s nxt_state;

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a < `RDC_A_END);
  endfunction : addr_ok

  // fixed-point reciprocal of the raw span trades exactness for no divider here
  function automatic logic signed [31:0] scale_raw(
    input logic [15:0]        raw,
    input logic signed [31:0] lo_u,
    input logic signed [31:0] hi_u,
    input logic [1:0]         rng
  );
    logic signed [17:0] d;
    logic signed [32:0] span;
    logic signed [63:0] rc;
    logic signed [63:0] prod;
    d    = $signed({2'h0, raw}) -
           ((rng == `RDC_RNG_LIVE) ? $signed(`RDC_RAW_LIVE_LO) : 18'sh0_0000);
    span = 33'(hi_u) - 33'(lo_u);
    rc   = (rng == `RDC_RNG_LIVE) ? 64'(`RDC_RECIP_LIVE) :
           (rng == `RDC_RNG_FULL) ? 64'(`RDC_RECIP_FULL) : 64'(`RDC_RECIP_VOLT);
    prod = 64'(d) * 64'(span) * rc;
    return lo_u + 32'(prod >>> `RDC_RECIP_SH);
  endfunction : scale_raw

  function automatic logic signed [31:0] consolidate(
    input logic               redundant,
    input logic [2:0]         sel,
    input logic signed [31:0] a,
    input logic signed [31:0] b
  );
    logic signed [32:0] sum;
    sum = 33'(a) + 33'(b);
    if (!redundant)
      return a;
    case (sel)
      `RDC_CS_RED: return b;
      `RDC_CS_MAX: return (a > b) ? a : b;
      `RDC_CS_MIN: return (a < b) ? a : b;
      `RDC_CS_AVG: return 32'(sum >>> 1);
      default:     return a;
    endcase
  endfunction : consolidate

  // hysteretic threshold, shared by the threshold comparator and the warning comparator when RDC_B_WARN_LOW is clear
  function automatic logic hyst_over(
    input logic               over,
    input logic signed [31:0] a,
    input logic signed [31:0] thr,
    input logic signed [31:0] hy
  );
    return over ? !(a < (thr - hy)) : (a > thr);
  endfunction : hyst_over

  logic [31:0]        ctrl;
  logic [1:0]         rng;
  logic               apb_acc;
  logic               apb_wr;
  logic [3:0]         cfg_idx;
  logic               cfg_hit;
  logic [31:0]        rd_mux;
  logic signed [31:0] res_c;
  logic               err_c;
  logic signed [31:0] w_hi;
  logic signed [31:0] w_lo;
  logic signed [31:0] w_hy;
  logic signed [31:0] sat_c;

  assign ctrl    = state_ff.cfg[`RDC_CTRL];
  assign rng     = ctrl[`RDC_B_RNG +: 2];
  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pwrite && addr_ok(paddr);
  assign cfg_idx = paddr[5:2];
  assign cfg_hit = paddr < `RDC_A_STATUS;
  assign w_hi    = state_ff.cfg[`RDC_WIN_HI];
  assign w_lo    = state_ff.cfg[`RDC_WIN_LO];
  assign w_hy    = state_ff.cfg[`RDC_WIN_HYST];
  assign sat_c   = ctrl[`RDC_B_SAT_HI] ? `RDC_SAT_HI : 32'h0000_0000;

  // mismatch only counts for a pair that is actually redundant
  assign err_c = (state_ff.dvs == 32'h0000_0000) || state_ff.anom.cable_open ||
                 state_ff.anom.out_ovl || state_ff.anom.in_ovl ||
                 (state_ff.anom.mismatch && (ctrl[`RDC_B_RED1] || ctrl[`RDC_B_RED2]));
  assign res_c = err_c ? sat_c :
                 (state_ff.neg ? -$signed(state_ff.quo) : $signed(state_ff.quo));

  always_comb
  begin
    case (paddr)
      `RDC_A_STATUS: rd_mux = {27'h000_0000, busy, state_ff.err, warning_output,
                               threshold_output, window_compare_output};
      `RDC_A_RESULT: rd_mux = state_ff.result;
      `RDC_A_CONS1:  rd_mux = state_ff.cons.cons1;
      `RDC_A_CONS2:  rd_mux = state_ff.cons.cons2;
      `RDC_A_DIFF1:  rd_mux = state_ff.cons.diff1;
      `RDC_A_DIFF2:  rd_mux = state_ff.cons.diff2;
      default:       rd_mux = cfg_hit ? state_ff.cfg[cfg_idx] : 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    logic [32:0] rem_sh;
    logic [31:0] mag1;
    logic [31:0] mag2;
    rem_sh = 33'h0_0000_0000;
    mag1   = 32'h0000_0000;
    mag2   = 32'h0000_0000;
    nxt_state       = state_ff;
    nxt_state.valid = 1'b0;
    if (psel && !penable)
      nxt_state.rdata = addr_ok(paddr) ? rd_mux : 32'h0000_0000;
    if (apb_wr && cfg_hit)
    begin
      for (int b = 0; b < 4; b++)
        if (pstrb[b])
          nxt_state.cfg[cfg_idx][8*b +: 8] = pwdata[8*b +: 8];
    end
    case (state_ff.st)
      rdc_pkg::RDC_IDLE:
      begin
        if (sample_valid)
        begin
          nxt_state.smp  = samples;
          nxt_state.anom = anomalies;
          nxt_state.st   = rdc_pkg::RDC_SCALE;
        end
      end
      rdc_pkg::RDC_SCALE:
      begin
        nxt_state.u1p = scale_raw(state_ff.smp.prim1, state_ff.cfg[`RDC_S1P_MIN],
                                  state_ff.cfg[`RDC_S1P_MAX], rng);
        nxt_state.u2p = scale_raw(state_ff.smp.prim2, state_ff.cfg[`RDC_S2P_MIN],
                                  state_ff.cfg[`RDC_S2P_MAX], rng);
        if (ctrl[`RDC_B_DIFF1])
          nxt_state.u1r = scale_raw(state_ff.smp.red1, state_ff.cfg[`RDC_S1R_MIN],
                                    state_ff.cfg[`RDC_S1R_MAX], rng);
        else
          nxt_state.u1r = scale_raw(state_ff.smp.red1, state_ff.cfg[`RDC_S1P_MIN],
                                    state_ff.cfg[`RDC_S1P_MAX], rng);
        if (ctrl[`RDC_B_DIFF2])
          nxt_state.u2r = scale_raw(state_ff.smp.red2, state_ff.cfg[`RDC_S2R_MIN],
                                    state_ff.cfg[`RDC_S2R_MAX], rng);
        else
          nxt_state.u2r = scale_raw(state_ff.smp.red2, state_ff.cfg[`RDC_S2P_MIN],
                                    state_ff.cfg[`RDC_S2P_MAX], rng);
        nxt_state.st = rdc_pkg::RDC_CONSOL;
      end
      rdc_pkg::RDC_CONSOL:
      begin
        nxt_state.cons.cons1 = consolidate(ctrl[`RDC_B_RED1], ctrl[`RDC_B_CONS1 +: 3],
                                           state_ff.u1p, state_ff.u1r);
        nxt_state.cons.cons2 = consolidate(ctrl[`RDC_B_RED2], ctrl[`RDC_B_CONS2 +: 3],
                                           state_ff.u2p, state_ff.u2r);
        nxt_state.cons.diff1 = state_ff.u1p - state_ff.u1r;
        nxt_state.cons.diff2 = state_ff.u2p - state_ff.u2r;
        mag1 = nxt_state.cons.cons1[31] ? 32'(-nxt_state.cons.cons1) : nxt_state.cons.cons1;
        mag2 = nxt_state.cons.cons2[31] ? 32'(-nxt_state.cons.cons2) : nxt_state.cons.cons2;
        nxt_state.quo = mag1;
        nxt_state.dvs = mag2;
        nxt_state.rem = 33'h0_0000_0000;
        nxt_state.neg = nxt_state.cons.cons1[31] ^ nxt_state.cons.cons2[31];
        nxt_state.cnt = 6'h00;
        nxt_state.st  = rdc_pkg::RDC_DIV;
      end
      rdc_pkg::RDC_DIV:
      begin
        // one quotient bit a cycle keeps the datapath to a single subtractor
        rem_sh = {state_ff.rem[31:0], state_ff.quo[31]};
        if (rem_sh >= {1'b0, state_ff.dvs})
        begin
          nxt_state.rem = rem_sh - {1'b0, state_ff.dvs};
          nxt_state.quo = {state_ff.quo[30:0], 1'b1};
        end
        else
        begin
          nxt_state.rem = rem_sh;
          nxt_state.quo = {state_ff.quo[30:0], 1'b0};
        end
        nxt_state.cnt = state_ff.cnt + 6'h01;
        if (state_ff.cnt == `RDC_DIV_STEPS)
          nxt_state.st = rdc_pkg::RDC_FINISH;
      end
      rdc_pkg::RDC_FINISH:
      begin
        nxt_state.result = res_c;
        nxt_state.err    = err_c;
        nxt_state.valid  = 1'b1;
        // window: state memory decides which pair of limits applies
        if (!ctrl[`RDC_B_WIN_EN])
          nxt_state.win_in = 1'b0;
        else if (state_ff.win_in)
          nxt_state.win_in = (res_c < w_hi) && (res_c > (w_lo + w_hy));
        else
          nxt_state.win_in = (res_c < (w_hi - w_hy)) && (res_c > w_lo);
        nxt_state.thr_over = ctrl[`RDC_B_THR_EN] &&
                             hyst_over(state_ff.thr_over, res_c, state_ff.cfg[`RDC_THR],
                                       state_ff.cfg[`RDC_THR_HYST]);
        if (!ctrl[`RDC_B_WARN_EN])
          nxt_state.warn_act = 1'b0;
        else if (ctrl[`RDC_B_WARN_LOW])
          nxt_state.warn_act = state_ff.warn_act ?
            !(res_c > ($signed(state_ff.cfg[`RDC_WARN_THR]) +
                       $signed(state_ff.cfg[`RDC_WARN_HYST]))) :
            (res_c < $signed(state_ff.cfg[`RDC_WARN_THR]));
        else
          nxt_state.warn_act = hyst_over(state_ff.warn_act, res_c, state_ff.cfg[`RDC_WARN_THR],
                                         state_ff.cfg[`RDC_WARN_HYST]);
        nxt_state.st = rdc_pkg::RDC_IDLE;
      end
      default:
        nxt_state.st = rdc_pkg::RDC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // zero wait states: read data was captured in the setup cycle
  assign pready                = 1'b1;
  assign pslverr               = apb_acc && !addr_ok(paddr);
  assign prdata                = state_ff.rdata;
  assign busy                  = state_ff.st != rdc_pkg::RDC_IDLE;
  assign result_valid          = state_ff.valid;
  assign division_value        = state_ff.result;
  assign analog_data           = state_ff.cons;
  assign math_err              = state_ff.err;
  assign window_compare_output = state_ff.win_in;
  assign threshold_output      = state_ff.thr_over;
  assign warning_output        = state_ff.warn_act;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_div_latency: assert property (state_ff.st == rdc_pkg::RDC_CONSOL |-> ##34 result_valid)
    else $error("result not ready 34 cycles after consolidation");

  a_valid_pulse: assert property (result_valid |=> !result_valid)
    else $error("result strobe longer than one cycle");

  a_cmp_hold: assert property (state_ff.st != rdc_pkg::RDC_FINISH && !$past(rst)
                               |=> $stable(window_compare_output) && $stable(threshold_output) &&
                                   $stable(warning_output))
    else $error("comparator moved outside a result update");

  a_sat_value: assert property (result_valid && math_err |-> division_value == sat_c)
    else $error("math error result not saturated");

  a_zero_div: assert property (state_ff.st == rdc_pkg::RDC_FINISH &&
                               state_ff.dvs == 32'h0000_0000 |=> math_err)
    else $error("divide by zero not flagged");

  a_win_enter: assert property (state_ff.st == rdc_pkg::RDC_FINISH && ctrl[`RDC_B_WIN_EN] &&
                                !window_compare_output && res_c < (w_hi - w_hy) && res_c > w_lo
                                |=> window_compare_output)
    else $error("window not entered");

  a_win_leave: assert property (state_ff.st == rdc_pkg::RDC_FINISH &&
                                window_compare_output && !(res_c < w_hi && res_c > (w_lo + w_hy))
                                |=> !window_compare_output)
    else $error("window not left");

  a_thr_rise: assert property (state_ff.st == rdc_pkg::RDC_FINISH && ctrl[`RDC_B_THR_EN] &&
                               !threshold_output && res_c > $signed(state_ff.cfg[`RDC_THR])
                               |=> threshold_output)
    else $error("threshold not crossed");

  a_cons_max: assert property (state_ff.st == rdc_pkg::RDC_CONSOL && ctrl[`RDC_B_RED1] &&
                               ctrl[`RDC_B_CONS1 +: 3] == `RDC_CS_MAX
                               |=> analog_data.cons1 >= $past(state_ff.u1p) &&
                                   analog_data.cons1 >= $past(state_ff.u1r) &&
                                   (analog_data.cons1 == $past(state_ff.u1p) ||
                                    analog_data.cons1 == $past(state_ff.u1r)))
    else $error("maximum consolidation wrong");

  a_equal_scale: assert property (state_ff.st == rdc_pkg::RDC_SCALE && !ctrl[`RDC_B_DIFF1] &&
                                  state_ff.smp.prim1 == state_ff.smp.red1
                                  |=> state_ff.u1p == state_ff.u1r)
    else $error("equal sensors scaled differently");

endmodule : rdc_top
`default_nettype wire

// File: dv/rdc_master_model.sv
// stand-in for the safety controller that consumes consolidated data
// assumes result_valid is a one-cycle strobe on clk
`default_nettype none
module rdc_master_model (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               result_valid,
  input  wire rdc_pkg::rdc_cons_s analog_data,
  output var rdc_pkg::rdc_cons_s  seen_cons
);
  timeunit 1ns;
  timeprecision 1ps;
  // takes the word only on the strobe, so stale data between results goes unseen
  always_ff @(posedge clk)
  begin
    if (rst)
      seen_cons <= '0;
    else if (result_valid)
      seen_cons <= analog_data;
  end
endmodule : rdc_master_model
`default_nettype wire

// File: dv/rdc_top_bench.sv
// self-checking bench of the redundant division block
// assumes rdc_map.svh offsets and the 36-cycle result latency
`include "rdc_map.svh"
`default_nettype none
module rdc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk, rst, psel, penable, pwrite, sample_valid;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [3:0]               pstrb;
  logic                     pready, pslverr, er, busy, result_valid, math_err;
  logic                     window_compare_output, threshold_output, warning_output;
  logic signed [31:0]       division_value;
  rdc_pkg::rdc_sample_s     samples;
  rdc_pkg::rdc_anom_s       anomalies;
  rdc_pkg::rdc_cons_s       analog_data, seen_cons;
  int                       failures, checked;
  rdc_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sample_valid(sample_valid), .samples(samples),
    .anomalies(anomalies), .busy(busy), .result_valid(result_valid),
    .division_value(division_value), .analog_data(analog_data), .math_err(math_err),
    .window_compare_output(window_compare_output), .threshold_output(threshold_output),
    .warning_output(warning_output));
  rdc_master_model peer (.clk(clk), .rst(rst), .result_valid(result_valid),
    .analog_data(analog_data), .seen_cons(seen_cons));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cfg(input logic [3:0] idx, input logic [31:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
  endtask : cfg
  task automatic run(input logic [15:0] p1, input logic [15:0] r1, input logic [3:0] an);
    int n;
    @(posedge clk);
    sample_valid <= 1'b1;
    samples <= {p1, r1, 16'h0000, 16'h0000};
    anomalies <= an;
    @(posedge clk);
    sample_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (result_valid !== 1'b1 && n < 100);
    chk("latency", 32'(n), 32'd36);
    @(negedge clk);
  endtask : run
  function automatic longint scl(input longint raw, input longint lo, input longint hi,
                                 input int rng);
    longint r;
    longint base;
    r = (rng == 0) ? 1048 : (rng == 1) ? 839 : 1678;
    base = (rng == 0) ? 4000 : 0;
    return lo + (((raw - base) * (hi - lo) * r) >>> 24);
  endfunction : scl
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0000);
    apb(1'b0, `RDC_A_STATUS, 32'h0000_0000);
    chk("status", rd, 32'h0000_0000);
    apb(1'b0, `RDC_A_END, 32'h0000_0000);
    chk("unmapped err", {31'h0, er}, 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ranges();
    longint top;
    cfg(`RDC_S1P_MIN, 32'h0000_0064);
    cfg(`RDC_S1P_MAX, 32'h0000_044c);
    cfg(`RDC_S2P_MIN, 32'h0000_0001);
    cfg(`RDC_S2P_MAX, 32'h0000_0001);
    for (int g = 0; g < 3; g++)
    begin
      top = (g == 2) ? 10000 : 20000;
      cfg(`RDC_CTRL, 32'(g) << `RDC_B_RNG);
      run((g == 0) ? 16'h0fa0 : 16'h0000, 16'(top), 4'h0);
      chk("cons1 min", analog_data.cons1, 32'd100);
      chk("diff1 max", analog_data.diff1, 32'(100 - scl(top, 100, 1100, g)));
      chk("div", division_value, 32'd100);
      chk("peer cons1", seen_cons.cons1, 32'd100);
      chk("cons2 single", analog_data.cons2, 32'd1);
      chk("diff2 equal", analog_data.diff2, 32'd0);
    end
    $display("test ranges done");
  endtask : t_ranges
  task automatic t_consol();
    longint a, b, e;
    cfg(`RDC_S1P_MIN, 32'h0000_0000);
    cfg(`RDC_S1P_MAX, 32'h0000_03e8);
    cfg(`RDC_S1R_MAX, 32'h0000_07d0);
    for (int d = 0; d < 2; d++)
      // selector 5 is unused and must fall back to the primary channel
      for (int m = 0; m < 6; m++)
      begin
        cfg(`RDC_CTRL, 32'h0000_0005 | (d << `RDC_B_DIFF1) | (m << `RDC_B_CONS1));
        run(16'd8000, 16'd6000, 4'h0);
        a = scl(8000, 0, 1000, 1);
        b = scl(6000, 0, d ? 2000 : 1000, 1);
        e = (m == 0) ? a : (m == 1) ? b : (m == 2) ? ((a > b) ? a : b) :
            (m == 3) ? ((a < b) ? a : b) : (m == 4) ? (a + b) / 2 : a;
        chk("cons1", analog_data.cons1, 32'(e));
        chk("diff1", analog_data.diff1, 32'(a - b));
        chk("div", division_value, 32'(e));
        apb(1'b0, `RDC_A_RESULT, 32'h0000_0000);
        chk("result word", rd, 32'(e));
      end
    $display("test consolidation done");
  endtask : t_consol
  task automatic t_compare();
    int raws[16] = '{2000, 4600, 5200, 11200, 11800, 12400, 4800, 5200, 10400, 9000,
                     7600, 5600, 0, 5600, 6400, 7200};
    logic w, t, v;
    longint a;
    {w, t, v} = 3'b000;
    for (int i = 0; i < 16; i++)
    begin
      cfg(`RDC_WIN_HI, 32'd600);
      if (i == 0 || i == 13)
      begin
        cfg(`RDC_CTRL, 32'h0000_7004 | ((i == 13) << `RDC_B_WARN_LOW));
        cfg(`RDC_WIN_LO, 32'd200);
        cfg(`RDC_WIN_HYST, 32'd50);
        cfg(`RDC_THR, 32'd500);
        cfg(`RDC_THR_HYST, 32'd100);
        cfg(`RDC_WARN_THR, 32'd300);
        cfg(`RDC_WARN_HYST, 32'd50);
      end
      a = scl(raws[i], 0, 1000, 1);
      w = w ? (a < 600 && a > 250) : (a < 550 && a > 200);
      t = t ? !(a < 400) : (a > 500);
      v = (i < 13) ? (v ? !(a < 250) : (a > 300)) : (v ? !(a > 350) : (a < 300));
      run(16'(raws[i]), 16'h0000, 4'h0);
      chk("window", {31'h0, window_compare_output}, {31'h0, w});
      chk("threshold", {31'h0, threshold_output}, {31'h0, t});
      chk("warning", {31'h0, warning_output}, {31'h0, v});
    end
    $display("test comparators done");
  endtask : t_compare
  task automatic t_math();
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 6; k++)
      begin
        cfg(`RDC_CTRL, 32'h0000_0005 | (s << `RDC_B_SAT_HI));
        cfg(`RDC_S2P_MIN, (k == 4) ? 32'h0000_0000 : 32'h0000_0001);
        cfg(`RDC_S2P_MAX, (k == 4) ? 32'h0000_0000 : 32'h0000_0001);
        run(16'd8000, 16'd8000, (k < 4) ? (4'h8 >> k) : 4'h0);
        chk("math err", {31'h0, math_err}, (k == 5) ? 32'h0 : 32'h1);
        chk("div sat", division_value,
            (k == 5) ? 32'(scl(8000, 0, 1000, 1)) : (s ? 32'd200000 : 32'd0));
      end
    $display("test math error done");
  endtask : t_math
  // reset in the middle of a divide must drop the result and all state
  task automatic t_midreset();
    chk("window before reset", {31'h0, window_compare_output}, 32'h0000_0001);
    @(posedge clk);
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (10) @(negedge clk);
    chk("busy in divide", {31'h0, busy}, 32'h0000_0001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("busy after reset", {31'h0, busy}, 32'h0000_0000);
    chk("window after reset", {31'h0, window_compare_output}, 32'h0000_0000);
    chk("result after reset", division_value, 32'h0000_0000);
    repeat (40) @(negedge clk);
    chk("no late result", {31'h0, result_valid}, 32'h0000_0000);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl after reset", rd, 32'h0000_0000);
    cfg(`RDC_S1P_MAX, 32'h0000_03e8);
    $display("test mid-run reset done");
  endtask : t_midreset
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // whole run needs well under 8000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial
  begin
    {rst, psel, penable, pwrite, sample_valid} = 5'b10000;
    {paddr, pwdata, pstrb, samples, anomalies} = '0;
    pstrb = 4'hf;
    failures = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ranges();
    t_consol();
    t_compare();
    t_midreset();
    t_math();
    finish_test();
  end
endmodule : rdc_top_bench
`default_nettype wire
